// >>> acq_memory_diag_load_path_tb_top.sv
// Testbench top joining the controller end and the memory end.
`timescale 1ns/1ps
module acq_memory_diag_load_path_tb_top;
   logic clk_in;
   logic rst_in;
   // APB master side.
   logic psel, penable, pwrite, pready;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   // Observed lines of the two memory ends.
   logic [2:0] we_a_n, we_b_n;
   logic [9:0] addr_a, addr_b;
   logic sel_a, sel_b;
   int fail_count = 0;
   int n_checks = 0;
   // Word bytes; the last two only push the word through the data registers.
   localparam logic [7:0] WORD [5] = '{8'hC1, 8'hB2, 8'hA3, 8'h00, 8'h00};
   amd_if link_a ();
   amd_if link_b ();
   amd_host u_amd_host (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(), .link(link_a));
   amd_device u_amd_device (.clk_in(clk_in), .rst_in(rst_in), .link(link_a),
      .byte_write_enables_n_out(we_a_n), .addr_out(addr_a), .step_clock_sel_out(sel_a));
   // Second memory end, driven directly by the bench in place of the controller.
   amd_device u_amd_device_b (.clk_in(clk_in), .rst_in(rst_in), .link(link_b),
      .byte_write_enables_n_out(we_b_n), .addr_out(addr_b), .step_clock_sel_out(sel_b));
   amd_sva u_amd_sva (.clk_in(clk_in), .rst_in(rst_in), .bus_data(link_a.bus_data),
      .port_addr(link_a.port_addr), .wr_stb(link_a.wr_stb), .rd_stb(link_a.rd_stb),
      .rd_data(link_a.rd_data), .rd_valid(link_a.rd_valid),
      .byte_write_enables_n_out(we_a_n), .addr_out(addr_a), .step_clock_sel_out(sel_a));
   // Free-running clock at 25 MHz.
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do @(posedge clk_in); while (pready !== 1'b1);
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Port write on the second link; one idle edge lets the outputs settle.
   task automatic dwr(input logic [7:0] p, input logic [7:0] d);
      @(posedge clk_in);
      link_b.port_addr <= p;
      link_b.bus_data <= d;
      link_b.wr_stb <= 1'b1;
      @(posedge clk_in);
      link_b.wr_stb <= 1'b0;
      link_b.bus_data <= ~d;
      @(posedge clk_in);
   endtask
   // Port read; the answer stands one cycle after the strobe.
   task automatic drd(input logic [7:0] p, input logic [7:0] exp);
      @(posedge clk_in);
      link_b.port_addr <= p;
      link_b.rd_stb <= 1'b1;
      @(posedge clk_in);
      link_b.rd_stb <= 1'b0;
      @(posedge clk_in);
      chk(32'({link_b.rd_valid, link_b.rd_data}), 32'({1'b1, exp}));
   endtask
   // Loads the address register in two parts, then disables loading.
   task automatic load_addr(input logic [9:0] a);
      dwr(amd_pkg::PORT_WE_LOAD, amd_pkg::WE_LOAD_LOW);
      dwr(amd_pkg::PORT_STEP, a[7:0]);
      dwr(amd_pkg::PORT_WE_LOAD, amd_pkg::WE_LOAD_HIGH);
      dwr(amd_pkg::PORT_STEP, {6'h00, a[9:8]});
      dwr(amd_pkg::PORT_WE_LOAD, amd_pkg::WE_IDLE);
   endtask
   // Hang guard, sized well above the expected run.
   initial begin
      repeat (20000) @(posedge clk_in);
      fail_count++;
      end_sim();
   end
   // Main sequence.
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {link_b.port_addr, link_b.bus_data, link_b.wr_stb, link_b.rd_stb} = '0;
      rst_in = 1'b1;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      apb(1'b0, amd_pkg::REG_STATUS, 32'h0);
      chk(rdv, 32'h0);
      drd(amd_pkg::PORT_POD_A_RB, 8'h00);
      drd(8'h20, 8'h00);
      dwr(amd_pkg::PORT_MEM_CTL, amd_pkg::MC_LOAD_ADDR);
      dwr(amd_pkg::PORT_DIAG, amd_pkg::DIAG_ENABLE_VAL);
      dwr(amd_pkg::PORT_CLK_SEL, amd_pkg::CLK_SEL_STEP);
      chk(32'(sel_b), 32'h1);
      load_addr(10'h35A);
      chk(32'(addr_b), 32'h35A);
      load_addr(amd_pkg::CHECK_ADDR);
      chk(32'(addr_b), 32'h0);
      // Store one word with all lanes enabled, then try to overwrite it disabled.
      dwr(amd_pkg::PORT_MEM_CTL, amd_pkg::MC_STORE);
      dwr(amd_pkg::PORT_WE_LOAD, 8'h18);
      chk(32'(we_b_n), 32'h0);
      for (int i = 0; i < 5; i++) dwr(amd_pkg::PORT_STEP, WORD[i]);
      dwr(amd_pkg::PORT_WE_LOAD, amd_pkg::WE_IDLE);
      chk(32'(we_b_n), 32'h7);
      for (int i = 0; i < 5; i++) dwr(amd_pkg::PORT_STEP, ~WORD[i]);
      dwr(amd_pkg::PORT_MEM_CTL, amd_pkg::MC_READBACK);
      drd(amd_pkg::PORT_POD_A_RB, 8'hA3);
      drd(amd_pkg::PORT_POD_B_RB, 8'hB2);
      drd(amd_pkg::PORT_POD_C_RB, 8'hC1);
      // The controller end runs its three-pass check against the first memory end.
      apb(1'b1, amd_pkg::REG_CTRL, 32'h1);
      for (int i = 0; i < 500; i++) begin
         apb(1'b0, amd_pkg::REG_STATUS, 32'h0);
         if (rdv[1] === 1'b1) break;
      end
      chk(32'(rdv[2:0]), 32'h2);
      apb(1'b0, amd_pkg::REG_RESULT, 32'h0);
      chk(rdv, 32'h0055AAAA);
      apb(1'b0, 8'h40, 32'h0);
      chk(rdv, 32'h0);
      end_sim();
   end
endmodule

// >>> amd_device.sv
// Acquisition memory end: latches, login registers, address register and RAM.
// Summary of operation
// - Memory loaded and read one byte only.
// - Three login registers assemble a word.
// - Controller byte buffered onto local test bus.
// - Data registers capture logins, RAM stores later.
// - Ports 0B 0C 0D return pod bytes.
// - Check writes 55 in one lane.
// - Tester reads three bytes, stops on mismatch.
// - Memory-control 20 enables address loading.
// - Diagnostic 0B enables test bus logins.
// - Value 80 selects single-step clock source.
// - Latch F7 enables low address load.
// - Single-step write clocks low address byte.
// - Second value loads top two address bits.
// - Control 10 lets RAM store data.
// - Six 1024x4 RAMs make 1024x24.
// - Acquisition-read routes RAM to readback ports.
// - All write enables high stops storing.
`timescale 1ns/1ps
module amd_device (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Controller side.
   amd_if.device link,
   // Observed control lines.
   output logic [2:0] byte_write_enables_n_out,
   output logic [9:0] addr_out,
   output logic step_clock_sel_out
);
   // Six 4-bit RAMs: two per byte lane, kept as one array per nibble.
   logic [3:0] ram_lo [0:2][0:amd_pkg::DEPTH-1];
   logic [3:0] ram_hi [0:2][0:amd_pkg::DEPTH-1];

   // All state of the block except the RAM arrays.
   typedef struct packed {
      logic [7:0] mem_ctl;  // Memory-control latch.
      logic [7:0] diag;  // Diagnostic latch.
      logic [7:0] we_load;  // Write-enable/address-load latch.
      logic step_sel;  // Single-step drives the RAM write clock.
      logic [23:0] login;  // Login word outputs.
      logic [23:0] data_reg;  // Memory data registers.
      logic [9:0] addr;  // Memory address register.
      logic [7:0] rd_data;  // Read answer.
      logic rd_valid;  // Read answer valid.
   } amd_state_t;

   amd_state_t state_r;
   amd_state_t state_nxt;
   logic [7:0] local_test_bus;  // Buffered controller byte.
   logic step;  // Single-step strobe this cycle.
   logic ram_write_clock;  // Third master clock event.
   logic addr_reg_enable_n;  // Address register enable, active low.
   logic diag_on;  // All pod diagnostic enables low.
   logic acquisition_read_ctl;  // Acquisition-read level.
   logic [2:0] we_n;  // Byte write enables, active low.
   logic [23:0] ram_word;  // RAM word at the address.

   // Decode of the latches into control levels.
   always_comb begin
      local_test_bus = link.bus_data;
      step = link.wr_stb && (link.port_addr == amd_pkg::PORT_STEP);
      // The third master clock only follows the strobe when selected.
      ram_write_clock = step && state_r.step_sel;
      addr_reg_enable_n = !state_r.mem_ctl[amd_pkg::MC_MEM_READ_BIT];
      diag_on = (state_r.diag == amd_pkg::DIAG_ENABLE_VAL);
      acquisition_read_ctl = state_r.mem_ctl[amd_pkg::MC_ACQ_READ_BIT];
      we_n = {state_r.we_load[amd_pkg::WE_C_BIT], state_r.we_load[amd_pkg::WE_B_BIT],
              state_r.we_load[amd_pkg::WE_A_BIT]};
      for (int i = 0; i < amd_pkg::LANES; i++) begin
         ram_word[i*8 +: 8] = {ram_hi[i][state_r.addr], ram_lo[i][state_r.addr]};
      end
   end

   // Next-state logic for latches, word pipeline, address and reads.
   always_comb begin
      state_nxt = state_r;
      state_nxt.rd_valid = 1'b0;
      if (link.wr_stb) begin
         unique case (link.port_addr)
            amd_pkg::PORT_MEM_CTL: begin
               state_nxt.mem_ctl = link.bus_data;
            end
            amd_pkg::PORT_DIAG: begin
               state_nxt.diag = link.bus_data;
            end
            amd_pkg::PORT_WE_LOAD: begin
               state_nxt.we_load = link.bus_data;
            end
            amd_pkg::PORT_CLK_SEL: begin
               // Port-C bit-4 strobe with the select value on the data lines.
               state_nxt.step_sel = (link.bus_data == amd_pkg::CLK_SEL_STEP);
            end
            default: begin
               // Other ports carry no write effect here.
            end
         endcase
      end
      if (step) begin
         // Login registers shift the test bus byte in, one lane per strobe.
         if (diag_on) begin
            state_nxt.login = {state_r.login[15:0], local_test_bus};
         end
         // Data registers take the login outputs on the second clock.
         state_nxt.data_reg = state_r.login;
      end
      if (ram_write_clock && !addr_reg_enable_n) begin
         if (!state_r.we_load[amd_pkg::LD_LOW_BIT]) begin
            state_nxt.addr[7:0] = local_test_bus;
         end
         if (!state_r.we_load[amd_pkg::LD_HIGH_BIT]) begin
            state_nxt.addr[9:8] = local_test_bus[1:0];
         end
      end
      if (link.rd_stb) begin
         state_nxt.rd_valid = 1'b1;
         // Readback only shows RAM when acquisition-read is high.
         unique case (link.port_addr)
            amd_pkg::PORT_POD_A_RB: begin
               state_nxt.rd_data = acquisition_read_ctl ? ram_word[7:0] : 8'h00;
            end
            amd_pkg::PORT_POD_B_RB: begin
               state_nxt.rd_data = acquisition_read_ctl ? ram_word[15:8] : 8'h00;
            end
            amd_pkg::PORT_POD_C_RB: begin
               state_nxt.rd_data = acquisition_read_ctl ? ram_word[23:16] : 8'h00;
            end
            default: begin
               state_nxt.rd_data = 8'h00;  // Unmapped ports read zero.
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= '{mem_ctl: amd_pkg::MC_RST, diag: amd_pkg::DIAG_RST,
                      we_load: amd_pkg::WE_RST, default: '0};
      end else begin
         state_r <= state_nxt;
      end
   end

   // RAM write: each enabled lane stores its data-register byte. Storing is
   // blocked while acquisition-read is high, since the data registers are off.
   always_ff @(posedge clk_in) begin
      for (int i = 0; i < amd_pkg::LANES; i++) begin
         if (ram_write_clock && !we_n[i] && !acquisition_read_ctl) begin
            ram_lo[i][state_r.addr] <= state_r.data_reg[i*8 +: 4];
            ram_hi[i][state_r.addr] <= state_r.data_reg[i*8+4 +: 4];
         end
      end
   end

   // Outputs straight from the state flip-flops.
   assign link.rd_data = state_r.rd_data;
   assign link.rd_valid = state_r.rd_valid;
   assign byte_write_enables_n_out = {state_r.we_load[amd_pkg::WE_C_BIT],
      state_r.we_load[amd_pkg::WE_B_BIT], state_r.we_load[amd_pkg::WE_A_BIT]};
   assign addr_out = state_r.addr;
   assign step_clock_sel_out = state_r.step_sel;
endmodule

// >>> amd_host.sv
// Controller end: runs the write-enable check and reports over APB.
`timescale 1ns/1ps
module amd_host (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // APB slave.
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Link to the device.
   amd_if.host link
);
   typedef enum {S_IDLE, S_CMD, S_WAIT_RD, S_NEXT} amd_phase_t;

   // One command of the check sequence.
   typedef struct packed {
      logic [7:0] port;
      logic [7:0] data;
      logic rd;
   } amd_cmd_t;

   typedef struct packed {
      amd_phase_t phase;
      logic [5:0] idx;  // Step within a pass.
      logic [1:0] pass;  // Pass number, 0 to 2.
      logic busy;
      logic done;
      logic fail;
      logic [23:0] got;  // Bytes read this pass.
      logic [7:0] port;
      logic [7:0] data;
      logic wr;
      logic rd;
      logic [31:0] prdata;
      logic pready;
   } amd_hstate_t;

   localparam int NCMD = 26;

   amd_hstate_t st_r;
   amd_hstate_t st_nxt;
   amd_cmd_t cmd;
   logic [2:0] wmask;  // Lanes written with 55 this pass, active low.
   logic [23:0] expect_w;

   // Command list of one pass of the write-enable check.
   always_comb begin
      wmask = ~(3'b001 << st_r.pass);
      expect_w = 24'h000000;
      for (int i = 0; i < amd_pkg::LANES; i++) begin
         expect_w[i*8 +: 8] = (i == int'(st_r.pass)) ? amd_pkg::PAT_ODD : amd_pkg::PAT_EVEN;
      end
      cmd = '{port: amd_pkg::PORT_STEP, data: amd_pkg::PAT_EVEN, rd: 1'b0};
      unique case (st_r.idx)
         6'h00: cmd = '{amd_pkg::PORT_MEM_CTL, amd_pkg::MC_LOAD_ADDR, 1'b0};
         6'h01: cmd = '{amd_pkg::PORT_DIAG, amd_pkg::DIAG_ENABLE_VAL, 1'b0};
         6'h02: cmd = '{amd_pkg::PORT_CLK_SEL, amd_pkg::CLK_SEL_STEP, 1'b0};
         6'h03: cmd = '{amd_pkg::PORT_WE_LOAD, amd_pkg::WE_LOAD_LOW, 1'b0};
         6'h04: cmd = '{amd_pkg::PORT_STEP, 8'h00, 1'b0};
         6'h05: cmd = '{amd_pkg::PORT_WE_LOAD, amd_pkg::WE_LOAD_HIGH, 1'b0};
         6'h06: cmd = '{amd_pkg::PORT_STEP, 8'h00, 1'b0};
         6'h07: cmd = '{amd_pkg::PORT_WE_LOAD, amd_pkg::WE_IDLE, 1'b0};
         6'h08: cmd = '{amd_pkg::PORT_MEM_CTL, amd_pkg::MC_STORE, 1'b0};
         // The enable low in wmask is the lane that takes 55 this pass.
         6'h09: cmd = '{amd_pkg::PORT_WE_LOAD, {wmask, 5'h1F}, 1'b0};
         // Five steps: three fill the login lanes, two push the word to the RAM.
         6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E: begin
            cmd = '{amd_pkg::PORT_STEP, amd_pkg::PAT_ODD, 1'b0};
         end
         6'h0F: cmd = '{amd_pkg::PORT_WE_LOAD, {~wmask, 5'h1F}, 1'b0};
         6'h10, 6'h11, 6'h12, 6'h13, 6'h14: begin
            cmd = '{amd_pkg::PORT_STEP, amd_pkg::PAT_EVEN, 1'b0};
         end
         6'h15: cmd = '{amd_pkg::PORT_WE_LOAD, amd_pkg::WE_STOP, 1'b0};
         6'h16: cmd = '{amd_pkg::PORT_MEM_CTL, amd_pkg::MC_READBACK, 1'b0};
         6'h17: cmd = '{amd_pkg::PORT_POD_A_RB, 8'h00, 1'b1};
         6'h18: cmd = '{amd_pkg::PORT_POD_B_RB, 8'h00, 1'b1};
         6'h19: cmd = '{amd_pkg::PORT_POD_C_RB, 8'h00, 1'b1};
         default: cmd = '{amd_pkg::PORT_STEP, 8'h00, 1'b0};
      endcase
   end

   // Sequencer and APB slave.
   always_comb begin
      st_nxt = st_r;
      st_nxt.wr = 1'b0;
      st_nxt.rd = 1'b0;
      st_nxt.pready = 1'b0;
      // APB: answer in the cycle after the access phase starts.
      if (psel_in && penable_in && !st_r.pready) begin
         st_nxt.pready = 1'b1;
         st_nxt.prdata = 32'h00000000;
         if (pwrite_in && paddr_in == amd_pkg::REG_CTRL && pwdata_in[0] && !st_r.busy) begin
            st_nxt.busy = 1'b1;
            st_nxt.done = 1'b0;
            st_nxt.fail = 1'b0;
            st_nxt.pass = 2'd0;
            st_nxt.idx = 6'h00;
            st_nxt.phase = S_CMD;
         end else if (!pwrite_in && paddr_in == amd_pkg::REG_STATUS) begin
            st_nxt.prdata = {27'h0, st_r.pass, st_r.fail, st_r.done, st_r.busy};
         end else if (!pwrite_in && paddr_in == amd_pkg::REG_RESULT) begin
            st_nxt.prdata = {8'h00, st_r.got};
         end
      end
      unique case (st_r.phase)
         S_IDLE: begin
         end
         S_CMD: begin
            st_nxt.port = cmd.port;
            st_nxt.data = cmd.data;
            st_nxt.wr = !cmd.rd;
            st_nxt.rd = cmd.rd;
            st_nxt.phase = cmd.rd ? S_WAIT_RD : S_NEXT;
         end
         S_WAIT_RD: begin
            if (link.rd_valid) begin
               st_nxt.got = {link.rd_data, st_r.got[23:8]};
               st_nxt.phase = S_NEXT;
            end
         end
         S_NEXT: begin
            st_nxt.phase = S_CMD;
            st_nxt.idx = st_r.idx + 6'h01;
            if (int'(st_r.idx) == NCMD - 1) begin
               st_nxt.idx = 6'h00;
               if (st_r.got != expect_w) begin
                  st_nxt.fail = 1'b1;
                  st_nxt.busy = 1'b0;
                  st_nxt.done = 1'b1;
                  st_nxt.phase = S_IDLE;
               end else if (int'(st_r.pass) == amd_pkg::PASSES - 1) begin
                  st_nxt.busy = 1'b0;
                  st_nxt.done = 1'b1;
                  st_nxt.phase = S_IDLE;
               end else begin
                  st_nxt.pass = st_r.pass + 2'd1;
               end
            end
         end
      endcase
   end

   // State register.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '{phase: S_IDLE, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs from the state flip-flops; pslverr_out is tied low.
   assign prdata_out = st_r.prdata;
   assign pready_out = st_r.pready;
   assign pslverr_out = 1'b0;
   assign link.bus_data = st_r.data;
   assign link.port_addr = st_r.port;
   assign link.wr_stb = st_r.wr;
   assign link.rd_stb = st_r.rd;
endmodule

// >>> amd_if.sv
// Interface joining the controller end to the acquisition memory end.
`timescale 1ns/1ps
interface amd_if;
   logic [7:0] bus_data;  // Controller data bus byte.
   logic [7:0] port_addr;  // Port address.
   logic wr_stb;  // One-cycle write strobe.
   logic rd_stb;  // One-cycle read strobe.
   logic [7:0] rd_data;  // Read data from the device.
   logic rd_valid;  // Read data valid pulse.
   modport device (input bus_data, port_addr, wr_stb, rd_stb, output rd_data, rd_valid);
   modport host (output bus_data, port_addr, wr_stb, rd_stb, input rd_data, rd_valid);
endinterface

// >>> amd_pkg.sv
// Package of constants shared by the acquisition memory diagnostic load path ends.
package amd_pkg;
   // Memory geometry: 1024 words of 24 bits, built as six 1024 by 4 RAMs.
   localparam int ADDR_W = 10;
   localparam int DEPTH = 1024;
   localparam int BYTE_W = 8;
   localparam int LANES = 3;
   // Port addresses on the controller interface.
   localparam logic [7:0] PORT_POD_A_RB = 8'h0B;
   localparam logic [7:0] PORT_POD_B_RB = 8'h0C;
   localparam logic [7:0] PORT_POD_C_RB = 8'h0D;
   localparam logic [7:0] PORT_MEM_CTL = 8'h10;
   localparam logic [7:0] PORT_DIAG = 8'h11;
   localparam logic [7:0] PORT_WE_LOAD = 8'h12;
   localparam logic [7:0] PORT_STEP = 8'h13;
   localparam logic [7:0] PORT_CLK_SEL = 8'h14;
   // Memory-control latch bits.
   localparam int MC_ACQ_READ_BIT = 0;
   localparam int MC_MEM_READ_BIT = 5;
   // Clock-select value placed on the data lines with the port-C bit-4 strobe.
   localparam logic [7:0] CLK_SEL_STEP = 8'h80;
   // Diagnostic latch: bits 0, 1 and 3 high with the rest low drive the pod enables low.
   localparam logic [7:0] DIAG_ENABLE_VAL = 8'h0B;
   // Write-enable/address-load latch bit positions.
   localparam int WE_A_BIT = 5;
   localparam int WE_B_BIT = 6;
   localparam int WE_C_BIT = 7;
   localparam int LD_LOW_BIT = 3;
   localparam int LD_HIGH_BIT = 4;
   // Latch values used by the controller sequences.
   localparam logic [7:0] MC_LOAD_ADDR = 8'h20;
   localparam logic [7:0] MC_STORE = 8'h10;
   localparam logic [7:0] MC_READBACK = 8'h31;
   localparam logic [7:0] WE_LOAD_LOW = 8'hF7;
   localparam logic [7:0] WE_LOAD_HIGH = 8'hEF;
   localparam logic [7:0] WE_IDLE = 8'hFF;
   localparam logic [7:0] WE_STOP = 8'h1F;
   // Reset values of the latches.
   localparam logic [7:0] MC_RST = 8'h00;
   localparam logic [7:0] DIAG_RST = 8'hFF;
   localparam logic [7:0] WE_RST = 8'hFF;
   // Test patterns and check address.
   localparam logic [7:0] PAT_ODD = 8'h55;
   localparam logic [7:0] PAT_EVEN = 8'hAA;
   localparam logic [9:0] CHECK_ADDR = 10'h000;
   localparam int PASSES = 3;
   localparam int STEPS_PER_LOAD = 3;
   // Host APB register offsets.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_RESULT = 8'h08;
endpackage

// >>> amd_sva.sv
// Checker of the link between the controller end and the memory end.
`timescale 1ns/1ps
module amd_sva (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Link signals.
   input wire logic [7:0] bus_data,
   input wire logic [7:0] port_addr,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   // Observed control lines of the memory end.
   input wire logic [2:0] byte_write_enables_n_out,
   input wire logic [9:0] addr_out,
   input wire logic step_clock_sel_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Shadow of the latches, so that gated behaviour can be predicted.
   typedef struct packed {logic [7:0] mc; logic [7:0] we; logic sel;} amd_shadow_t;
   amd_shadow_t sh_r;
   amd_shadow_t sh_nxt;
   logic we_w; // Write to the enable and load latch.
   logic step_w; // Single-step write.
   logic pod_w; // Address is one of the readback ports.
   assign we_w = wr_stb && port_addr == amd_pkg::PORT_WE_LOAD;
   assign step_w = wr_stb && port_addr == amd_pkg::PORT_STEP;
   assign pod_w = port_addr inside {amd_pkg::PORT_POD_A_RB, amd_pkg::PORT_POD_B_RB,
      amd_pkg::PORT_POD_C_RB};
   // Next shadow value follows writes to the memory-control, enable/load and clock-select latches.
   always_comb begin
      sh_nxt = sh_r;
      if (wr_stb && port_addr == amd_pkg::PORT_MEM_CTL) begin
         sh_nxt.mc = bus_data;
      end
      if (we_w) begin
         sh_nxt.we = bus_data;
      end
      if (wr_stb && port_addr == amd_pkg::PORT_CLK_SEL) begin
         sh_nxt.sel = bus_data == amd_pkg::CLK_SEL_STEP;
      end
   end
   // The shadow resets with the latches it mirrors.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sh_r <= '{amd_pkg::MC_RST, amd_pkg::WE_RST, 1'b0};
      end else begin
         sh_r <= sh_nxt;
      end
   end
   AST_RD_ANSWER: assert property (rd_stb |=> rd_valid)
      else $error("Read strobe got no answer.");
   AST_RD_NO_SPURIOUS: assert property (rd_valid |-> $past(rd_stb))
      else $error("Read answer without a request.");
   AST_UNMAPPED_ZERO: assert property (rd_stb && !pod_w |=> rd_data == 8'h00)
      else $error("Unmapped read returned data.");
   AST_POD_GATED: assert property (rd_stb && pod_w && !sh_r.mc[amd_pkg::MC_ACQ_READ_BIT]
      |=> rd_data == 8'h00)
      else $error("Pod read without acquisition read.");
   AST_WE_FOLLOWS: assert property (we_w |=> byte_write_enables_n_out == $past(bus_data[7:5]))
      else $error("Write enables did not follow the latch.");
   AST_WE_HOLDS: assert property (!we_w |=> $stable(byte_write_enables_n_out))
      else $error("Write enables moved without a write.");
   AST_SEL_SET: assert property (wr_stb && port_addr == amd_pkg::PORT_CLK_SEL
      && bus_data == amd_pkg::CLK_SEL_STEP |=> step_clock_sel_out)
      else $error("Single-step clock not selected.");
   AST_ADDR_HOLDS: assert property (!step_w |=> $stable(addr_out))
      else $error("Address moved without a step.");
   AST_ADDR_LOW: assert property (step_w && sh_r.sel && sh_r.mc[amd_pkg::MC_MEM_READ_BIT]
      && !sh_r.we[amd_pkg::LD_LOW_BIT] |=> addr_out[7:0] == $past(bus_data))
      else $error("Low address byte not loaded.");
   AST_ADDR_HIGH: assert property (step_w && sh_r.sel && sh_r.mc[amd_pkg::MC_MEM_READ_BIT]
      && !sh_r.we[amd_pkg::LD_HIGH_BIT] |=> addr_out[9:8] == $past(bus_data[1:0]))
      else $error("High address bits not loaded.");
   CV_READ: cover property (rd_stb ##1 rd_valid);
   CV_LANE_WRITE: cover property (step_w && sh_r.sel && !sh_r.we[amd_pkg::WE_A_BIT]);
   CV_ADDR_LOAD: cover property (step_w && sh_r.mc[amd_pkg::MC_MEM_READ_BIT]);
endmodule
